// *** cie_consts.svh ***
// constants for the clear-instruction execute block
// Behaviour
// RULE1: clear-file opcode writes 00h to addressed file
// RULE2: clear-file sets zero flag, other flags kept
// RULE3: watchdog-clear zeroes counter, one word, one cycle
// RULE4: watchdog-clear also zeroes the watchdog prescaler
// RULE5: watchdog-clear sets timeout and powerdown flags
// RULE6: clear-working zeroes working register, sets zero
`ifndef CIE_CONSTS_SVH
`define CIE_CONSTS_SVH

// apb register byte addresses
`define CIE_ADDR_INSTR     8'h00
`define CIE_ADDR_WORK      8'h04
`define CIE_ADDR_STATUS    8'h08
`define CIE_ADDR_WDOG      8'h0C
`define CIE_ADDR_FADDR     8'h10
`define CIE_ADDR_FDATA     8'h14

// status register field positions
`define CIE_ST_ZERO        0
`define CIE_ST_PD_N        3
`define CIE_ST_TO_N        4

// watchdog register field positions
`define CIE_WD_CNT_LSB     0
`define CIE_WD_PRE_LSB     8

// opcode patterns
`define CIE_OP_CLEAR_FILE_OP_HI     7'h03
`define CIE_OP_CLEAR_WORKING_OP_HI     7'h02
`define CIE_OP_CLEAR_WATCHDOG_OP      14'h0064

// reset and cleared values
`define CIE_RST_WORK       8'h00
`define CIE_CLEAR_BYTE     8'h00
`define CIE_RST_FLAG       1'b1

`endif

// *** cie_pkg.sv ***
// types shared by the clear-instruction execute block
package cie_pkg;

   // instruction phase, gray along idle-q1-q2-q3-q4
   typedef enum logic [2:0] {
      CIE_IDLE = 3'h0,
      CIE_Q1   = 3'h1,
      CIE_Q2   = 3'h3,
      CIE_Q3   = 3'h2,
      CIE_Q4   = 3'h6
   } cie_phase_t;

   // decoded instruction class
   typedef enum logic [1:0] {
      CIE_OP_NONE = 2'h0,
      CIE_OP_FILE = 2'h1,
      CIE_OP_WORK = 2'h2,
      CIE_OP_WDOG = 2'h3
   } cie_op_t;

endpackage

// *** cie_file_mem.sv ***
// file register memory, one write port, registered read port
`timescale 1ns/1ps

module cie_file_mem #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   // storage array, no reset: contents are software state
   logic [DW-1:0] mem_r [0:(1<<AW)-1];

   // write port
   always_ff @(posedge clk) begin
      if (we) begin
         mem_r[waddr] <= wdata;
      end
   end

   // read data from a register, old data on same-address write
   always_ff @(posedge clk) begin
      rdata <= mem_r[raddr];
   end

endmodule

// *** cie_core.sv ***
// clear-instruction decode and execute with apb register access
`timescale 1ns/1ps
`include "cie_consts.svh"

module cie_core #(
   parameter int PRE_W = 8,   // watchdog prescaler width
   parameter int WDT_W = 8    // watchdog counter width
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // instruction fetch side
   input  wire logic             instr_valid,
   input  wire logic [13:0]      instr_word,
   output logic                  instr_ready,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // core side results
   output logic      [7:0]       working_reg,
   output logic                  zero_flag,
   output logic                  timeout_flag_n,
   output logic                  powerdown_flag_n,
   output logic      [WDT_W-1:0] watchdog_counter,
   output logic                  watchdog_clear,
   output cie_pkg::cie_op_t      last_op
);
   import cie_pkg::*;

   // refuse widths the watchdog register layout cannot hold
   if (PRE_W < 1 || PRE_W > 24 || WDT_W < 1 || WDT_W > 8) begin : g_bad
      $error("cie_core: unsupported watchdog width");
   end

   ////////////////////////////////////////////////////////////////////
   // declarations

   cie_phase_t       phase_r;        // current instruction phase
   cie_phase_t       phase_nxt;      // next phase
   cie_op_t          op_r;           // class of instruction in flight
   cie_op_t          op_dec;         // class decoded from new word
   logic [13:0]      iword_r;        // instruction in flight
   logic [13:0]      new_word;       // word being launched
   logic             launch;         // a new instruction starts
   logic             apb_launch;     // launch comes from apb
   logic             idle;           // engine not executing
   logic             idle_q_r;       // engine idle last cycle too
   logic [7:0]       work_r;         // working register
   logic             zero_r;         // zero flag
   logic             to_n_r;         // timeout flag, active low
   logic             pd_n_r;         // powerdown flag, active low
   logic [PRE_W-1:0] pre_r;          // watchdog prescaler
   logic [WDT_W-1:0] wdt_r;          // watchdog counter
   logic [6:0]       faddr_r;        // apb file pointer
   logic [6:0]       mem_raddr;      // memory read address
   logic [7:0]       mem_rdata;      // memory read data
   logic             mem_we;         // memory write enable
   logic [6:0]       mem_waddr;      // memory write address
   logic [7:0]       mem_wdata;      // memory write data
   logic             exec_q4;        // write phase of an instruction
   logic             wr_acc;         // apb write access phase
   logic             rd_acc;         // apb read access phase
   logic             rd_ok_r;        // read data captured and stable
   logic             mapped;         // address hits a register
   logic             wr_done;        // apb write completes this edge
   logic [31:0]      rd_mux;         // read data before register
   logic [31:0]      prdata_r;       // registered read data

   ////////////////////////////////////////////////////////////////////
   // decode

   // classify a word by its opcode bits
   function automatic cie_op_t classify(input logic [13:0] w);
      cie_op_t c;
      c = CIE_OP_NONE;
      if (w[13:7] == `CIE_OP_CLEAR_FILE_OP_HI) begin
         c = CIE_OP_FILE;                       // RULE1
      end else if (w[13:7] == `CIE_OP_CLEAR_WORKING_OP_HI) begin
         c = CIE_OP_WORK;                       // RULE6
      end else if (w == `CIE_OP_CLEAR_WATCHDOG_OP) begin
         c = CIE_OP_WDOG;                       // RULE3
      end
      return c;
   endfunction

   // a new word may start in idle or in the last phase
   assign idle        = (phase_r == CIE_IDLE);
   assign instr_ready = idle || (phase_r == CIE_Q4);
   assign exec_q4     = (phase_r == CIE_Q4);

   // fetch has priority over apb-issued words
   assign wr_acc     = psel && penable && pwrite;
   assign rd_acc     = psel && penable && !pwrite;
   assign apb_launch = wr_acc && idle && !instr_valid
                       && (paddr == `CIE_ADDR_INSTR);
   assign launch     = (instr_valid && instr_ready) || apb_launch;
   assign new_word   = instr_valid ? instr_word : pwdata[13:0];
   assign op_dec     = classify(new_word);

   ////////////////////////////////////////////////////////////////////
   // phase sequencer

   // four phases per instruction cycle, back to back allowed
   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         CIE_IDLE: begin
            if (launch) begin
               phase_nxt = CIE_Q1;
            end
         end
         CIE_Q1: begin
            phase_nxt = CIE_Q2;
         end
         CIE_Q2: begin
            phase_nxt = CIE_Q3;
         end
         CIE_Q3: begin
            phase_nxt = CIE_Q4;
         end
         CIE_Q4: begin
            // one word, one cycle: next word enters here
            phase_nxt = launch ? CIE_Q1 : CIE_IDLE;  // RULE3
         end
         default: begin
            phase_nxt = CIE_IDLE;
         end
      endcase
   end

   // phase register and idle history
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_r  <= CIE_IDLE;
         idle_q_r <= 1'b1;
      end else begin
         phase_r  <= phase_nxt;
         idle_q_r <= idle;
      end
   end

   // latch the word and its class on launch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         iword_r <= 14'h0000;
         op_r    <= CIE_OP_NONE;
      end else if (launch) begin
         iword_r <= new_word;
         op_r    <= op_dec;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // file register memory

   // read address follows the instruction only in its read phases
   assign mem_raddr = (phase_r == CIE_Q1 || phase_r == CIE_Q2)
                      ? iword_r[6:0] : faddr_r;

   // q4 clear wins the port; apb writes only happen in idle
   always_comb begin
      mem_we    = 1'b0;
      mem_waddr = faddr_r;
      mem_wdata = pwdata[7:0];
      if (exec_q4 && op_r == CIE_OP_FILE) begin
         mem_we    = 1'b1;                      // RULE1
         mem_waddr = iword_r[6:0];              // RULE1
         mem_wdata = `CIE_CLEAR_BYTE;           // RULE1
      end else if (wr_acc && idle && paddr == `CIE_ADDR_FDATA) begin
         mem_we    = 1'b1;
      end
   end

   cie_file_mem #(
      .AW (7),
      .DW (8)
   ) u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////
   // working register and status flags

   // apb writes land only when the engine is idle
   assign wr_done = wr_acc && idle;

   // working register: cleared by its opcode, else software
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         work_r <= `CIE_RST_WORK;
      end else if (exec_q4 && op_r == CIE_OP_WORK) begin
         work_r <= `CIE_CLEAR_BYTE;             // RULE6
      end else if (wr_done && paddr == `CIE_ADDR_WORK) begin
         work_r <= pwdata[7:0];
      end
   end

   // zero flag: hardware set beats a software write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         zero_r <= 1'b0;
      end else if (exec_q4 && (op_r == CIE_OP_FILE || op_r == CIE_OP_WORK)) begin
         zero_r <= 1'b1;                        // RULE2 RULE6
      end else if (wr_done && paddr == `CIE_ADDR_STATUS) begin
         zero_r <= pwdata[`CIE_ST_ZERO];
      end
   end

   // timeout and powerdown flags, set by the watchdog-clear opcode, untouched by the other clear opcodes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         to_n_r <= `CIE_RST_FLAG;
         pd_n_r <= `CIE_RST_FLAG;
      end else if (exec_q4 && op_r == CIE_OP_WDOG) begin
         to_n_r <= 1'b1;                        // RULE5
         pd_n_r <= 1'b1;                        // RULE5
      end else if (wr_done && paddr == `CIE_ADDR_STATUS) begin
         // software may drop them to model sleep or timeout
         to_n_r <= pwdata[`CIE_ST_TO_N];
         pd_n_r <= pwdata[`CIE_ST_PD_N];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // watchdog counter

   // free-running prescaler, counter steps on prescaler wrap;
   // the timeout reaction itself lives outside this block
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pre_r <= '0;
         wdt_r <= '0;
      end else if (exec_q4 && op_r == CIE_OP_WDOG) begin
         pre_r <= '0;                           // RULE4
         wdt_r <= '0;                           // RULE3
      end else begin
         pre_r <= pre_r + 1'b1;
         if (&pre_r) begin
            wdt_r <= wdt_r + 1'b1;
         end
      end
   end

   // one-cycle strobe to any external watchdog logic
   assign watchdog_clear = exec_q4 && (op_r == CIE_OP_WDOG);  // RULE3

   ////////////////////////////////////////////////////////////////////
   // apb register file

   // file pointer for software access to the memory
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         faddr_r <= 7'h00;
      end else if (wr_done && paddr == `CIE_ADDR_FADDR) begin
         faddr_r <= pwdata[6:0];
      end
   end

   // address decode, word aligned
   always_comb begin
      case (paddr)
         `CIE_ADDR_INSTR,
         `CIE_ADDR_WORK,
         `CIE_ADDR_STATUS,
         `CIE_ADDR_WDOG,
         `CIE_ADDR_FADDR,
         `CIE_ADDR_FDATA: mapped = 1'b1;
         default:         mapped = 1'b0;
      endcase
   end

   // read mux, reserved bits read as zero
   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr)
         `CIE_ADDR_INSTR: begin
            rd_mux[13:0] = iword_r;
         end
         `CIE_ADDR_WORK: begin
            rd_mux[7:0] = work_r;
         end
         `CIE_ADDR_STATUS: begin
            rd_mux[`CIE_ST_ZERO] = zero_r;
            rd_mux[`CIE_ST_PD_N] = pd_n_r;
            rd_mux[`CIE_ST_TO_N] = to_n_r;
         end
         `CIE_ADDR_WDOG: begin
            rd_mux[`CIE_WD_CNT_LSB +: WDT_W] = wdt_r;
            rd_mux[`CIE_WD_PRE_LSB +: PRE_W] = pre_r;
         end
         `CIE_ADDR_FADDR: begin
            rd_mux[6:0] = faddr_r;
         end
         `CIE_ADDR_FDATA: begin
            rd_mux[7:0] = mem_rdata;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   // capture read data once the engine has been quiet two cycles,
   // so memory data and flags cannot move under a read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata_r <= 32'h00000000;
         rd_ok_r  <= 1'b0;
      end else begin
         prdata_r <= rd_mux;
         rd_ok_r  <= rd_acc && idle && idle_q_r && !pready;
      end
   end

   // ready: writes when idle (instr also waits for fetch), reads
   // one cycle after a stable capture; unmapped answers at once
   always_comb begin
      pready = 1'b0;
      if (psel && penable) begin
         if (!mapped) begin
            pready = 1'b1;
         end else if (pwrite) begin
            pready = idle && !(paddr == `CIE_ADDR_INSTR && instr_valid);
         end else begin
            pready = rd_ok_r && idle;
         end
      end
   end

   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_r;

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign working_reg      = work_r;
   assign zero_flag        = zero_r;
   assign timeout_flag_n   = to_n_r;
   assign powerdown_flag_n = pd_n_r;
   assign watchdog_counter = wdt_r;
   assign last_op          = op_r;

endmodule

// *** cie_checker.sv ***
// assertion checker for the clear-instruction execute block
`timescale 1ns/1ps
`include "cie_consts.svh"

module cie_checker #(
   parameter int WDT_W = 8   // watchdog counter width
) (
   input logic             clk,
   input logic             sys_rst,
   input logic             instr_valid,
   input logic [13:0]      instr_word,
   input logic             instr_ready,
   input logic             psel,
   input logic             penable,
   input logic             pwrite,
   input logic [7:0]       paddr,
   input logic [31:0]      pwdata,
   input logic [31:0]      prdata,
   input logic             pready,
   input logic             pslverr,
   input logic [7:0]       working_reg,
   input logic             zero_flag,
   input logic             timeout_flag_n,
   input logic             powerdown_flag_n,
   input logic [WDT_W-1:0] watchdog_counter,
   input logic             watchdog_clear,
   input cie_pkg::cie_op_t last_op
);
   import cie_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // a word handed over by the fetch side, and its classes
   sequence take_s; instr_valid && instr_ready; endsequence
   sequence take_wd_s; take_s ##0 instr_word == `CIE_OP_CLEAR_WATCHDOG_OP; endsequence
   sequence take_file_s; take_s ##0 instr_word[13:7] == `CIE_OP_CLEAR_FILE_OP_HI; endsequence
   sequence take_work_s; take_s ##0 instr_word[13:7] == `CIE_OP_CLEAR_WORKING_OP_HI; endsequence
   sequence take_other_s;
      take_s ##0 (instr_word != `CIE_OP_CLEAR_WATCHDOG_OP && instr_word[13:8] != 6'h01);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   phase_span_a: assert property (take_s |=> !instr_ready [*3] ##1 instr_ready)
      else $error("word did not take four phases");
   wd_pulse_a: assert property (take_wd_s |-> ##4 watchdog_clear)
      else $error("watchdog clear strobe missing in last phase");
   wd_single_a: assert property (watchdog_clear |=> !watchdog_clear)
      else $error("watchdog clear strobe longer than one cycle");
   wd_result_a: assert property (watchdog_clear |=> watchdog_counter == '0
      && timeout_flag_n && powerdown_flag_n)
      else $error("watchdog clear left counter or flags");
   // class is looked at in q4, before a back-to-back word replaces it
   work_clear_a: assert property (take_work_s |-> ##4 (last_op == CIE_OP_WORK)
      ##1 (working_reg == 8'h00 && zero_flag))
      else $error("working register not cleared");
   file_zero_a: assert property (take_file_s |-> ##4 (last_op == CIE_OP_FILE)
      ##1 zero_flag)
      else $error("file clear did not set zero");
   file_keep_a: assert property (take_file_s ##4 1'b1 |=> $stable(timeout_flag_n)
      && $stable(powerdown_flag_n))
      else $error("file clear touched other flags");
   other_none_a: assert property (take_other_s |-> ##4 last_op == CIE_OP_NONE)
      else $error("unknown word not treated as no-op");
   unmapped_a: assert property (psel && penable && pready |->
      pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0))
      else $error("error response on wrong address");
endmodule

// *** clear_instruction_execute_test.sv ***
// self-checking testbench for the clear-instruction execute block
`timescale 1ns/1ps
`include "cie_consts.svh"

module clear_instruction_execute_test;
   import cie_pkg::*;
   localparam logic [32:0] ALL = 33'h1FFFFFFFF;  // compare every bit
   logic clk, sys_rst, instr_valid, instr_ready;  // clock, reset, fetch handshake
   logic [13:0] instr_word;                       // offered word
   logic psel, penable, pwrite, pready, pslverr;  // apb control
   logic [7:0] paddr, working_reg;                // apb address, working register
   logic [31:0] pwdata, prdata, rd;               // apb data, last read data
   logic zero_flag, timeout_flag_n, powerdown_flag_n, watchdog_clear;  // flags
   logic [7:0] watchdog_counter;                  // watchdog count
   cie_op_t last_op;                              // last decoded class
   logic [32:0] exp_q[$], msk_q[$];               // notes of {pslverr, prdata}
   logic [6:0] fa;                                // random file address
   logic [7:0] dv;                                // random nonzero byte
   int err_count, checked;                        // counters
   cie_core #(.PRE_W(8), .WDT_W(8)) dut_u (.clk(clk), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .working_reg(working_reg),
      .zero_flag(zero_flag), .timeout_flag_n(timeout_flag_n),
      .powerdown_flag_n(powerdown_flag_n), .watchdog_counter(watchdog_counter),
      .watchdog_clear(watchdog_clear), .last_op(last_op));
   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // verdict, shared by the main sequence and the watchdog
   task automatic give_verdict();
      if (err_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // hang guard, far past the expected run length
   initial begin
      #100000;
      err_count++;
      give_verdict();
   end
   // apb transfer; pready looked at just before the completing edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_count++;
         $display("wrong value at %0t: no pready from address %h", $time, a);
      end
      rd = prdata;
      @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // read with a note of the expected answer
   task automatic rd_chk(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask
   // fetch offer, held until the block takes it
   task automatic fetch(input logic [13:0] w);
      int n;
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (instr_ready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         $display("wrong value at %0t: word %h never taken", $time, w);
      end
      @(posedge clk);
      instr_valid <= 1'b0;
   endtask
   // watcher: oldest note against each completed read
   always @(negedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         checked++;
         if ((({pslverr, prdata} ^ exp_q[0]) & msk_q[0]) !== 33'h0) begin
            err_count++;
            $display("wrong value at %0t: read of %h gave %h", $time, paddr, prdata);
         end
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int k;
      {sys_rst, instr_valid, instr_word, psel, penable, pwrite, paddr, pwdata} = '0;
      sys_rst = 1'b1;
      err_count = 0;
      checked = 0;
      void'($urandom(61));
      fa = 7'($urandom);
      dv = 8'h01 + 8'($urandom % 255);
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd_chk(`CIE_ADDR_STATUS, 33'h18, ALL);
      rd_chk(`CIE_ADDR_WORK, 33'h0, ALL);
      rd_chk(8'h20, 33'h100000000, 33'h100000000);
      // clear-working with random don't-care bits
      apb(1'b1, `CIE_ADDR_WORK, {24'h0, dv});
      apb(1'b1, `CIE_ADDR_STATUS, 32'h0);
      fetch({`CIE_OP_CLEAR_WORKING_OP_HI, 7'($urandom)});
      rd_chk(`CIE_ADDR_WORK, 33'h0, ALL);
      rd_chk(`CIE_ADDR_STATUS, 33'h1, ALL);
      // clear-file at a random address, other flags kept low
      apb(1'b1, `CIE_ADDR_STATUS, 32'h0);
      apb(1'b1, `CIE_ADDR_FADDR, {25'h0, fa});
      apb(1'b1, `CIE_ADDR_FDATA, {24'h0, dv});
      fetch({`CIE_OP_CLEAR_FILE_OP_HI, fa});
      rd_chk(`CIE_ADDR_FDATA, 33'h0, ALL);
      rd_chk(`CIE_ADDR_STATUS, 33'h1, ALL);
      // near-miss word must change nothing; working register reloaded first
      apb(1'b1, `CIE_ADDR_WORK, {24'h0, dv});
      apb(1'b1, `CIE_ADDR_STATUS, 32'h0);
      fetch(14'h0065);
      rd_chk(`CIE_ADDR_WORK, {25'h0, dv}, ALL);
      rd_chk(`CIE_ADDR_STATUS, 33'h0, ALL);
      // watchdog clear while the prescaler is deep in its count
      repeat (600) @(posedge clk);
      k = 0;
      do begin
         rd_chk(`CIE_ADDR_WDOG, 33'h0, 33'h0);
         k++;
      end while (!(rd[15:8] inside {[8'h80:8'hC0]}) && k < 200);
      fetch(`CIE_OP_CLEAR_WATCHDOG_OP);
      rd_chk(`CIE_ADDR_WDOG, 33'h0, 33'hF0FF);
      rd_chk(`CIE_ADDR_STATUS, 33'h18, ALL);
      // watchdog clear launched by software
      apb(1'b1, `CIE_ADDR_STATUS, 32'h0);
      apb(1'b1, `CIE_ADDR_INSTR, 32'h64);
      rd_chk(`CIE_ADDR_STATUS, 33'h18, ALL);
      // three words back to back
      apb(1'b1, `CIE_ADDR_STATUS, 32'h0);
      apb(1'b1, `CIE_ADDR_WORK, {24'h0, dv});
      apb(1'b1, `CIE_ADDR_FADDR, {25'h0, fa ^ 7'h01});
      apb(1'b1, `CIE_ADDR_FDATA, {24'h0, dv});
      fetch(`CIE_OP_CLEAR_WATCHDOG_OP);
      fetch({`CIE_OP_CLEAR_FILE_OP_HI, fa ^ 7'h01});
      fetch({`CIE_OP_CLEAR_WORKING_OP_HI, 7'h7F});
      rd_chk(`CIE_ADDR_WORK, 33'h0, ALL);
      rd_chk(`CIE_ADDR_FDATA, 33'h0, ALL);
      rd_chk(`CIE_ADDR_STATUS, 33'h19, ALL);
      give_verdict();
   end
endmodule

bind cie_core cie_checker #(.WDT_W(WDT_W)) chk_u (.clk(clk), .sys_rst(sys_rst),
   .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .working_reg(working_reg),
   .zero_flag(zero_flag), .timeout_flag_n(timeout_flag_n),
   .powerdown_flag_n(powerdown_flag_n), .watchdog_counter(watchdog_counter),
   .watchdog_clear(watchdog_clear), .last_op(last_op));
